// ==== dv/module_reset_wake_control_tb.sv ====
`timescale 1ns/1ps
module module_reset_wake_control_tb;
  localparam int AC = 20;
  localparam int LC = 10;
  logic clk = 0, srst = 1, rst_low = 0, con = 1, wake_req = 0;
  logic rin_n, wake_in, wake_out, wake_oe, dp, rep, hra;
  int n_fail = 0, n_tests = 0, n;
  int len;
  logic seen;
  mrw_core #(.ATTACH_CYC(AC), .LEAD_CYC(LC)) uut (.clk(clk), .srst(srst),
    .module_reset_in_n(rin_n), .reset_pin_driven(con), .wake_req(wake_req),
    .wake_in(wake_in), .wake_out(wake_out), .wake_oe(wake_oe), .usb_dp_pullup(dp),
    .startup_report(rep), .hw_reset_active(hra));
  mrw_host #(.MAX_LOW(50)) host (.clk(clk), .rst_low(rst_low), .connected(con),
    .wake_oe(wake_oe), .wake_out(wake_out), .module_reset_in_n(rin_n), .wake_in(wake_in));
  initial forever #10 clk = ~clk;
  task automatic print_verdict;
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic got, input logic exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : chk
  // a low run is taken once it lasts at least as long as the glitch filter
  function automatic logic exp_taken(input int cyc_low);
    return cyc_low >= int'(mrw_pkg::GLITCH_CYC);
  endfunction : exp_taken
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc
  // pull-up must rise lo..lo+11 cycles on, then one report pulse
  task automatic wait_up(input int lo);
    n = 0;
    while (dp !== 1'b1 && n < lo + 12) begin
      @(negedge clk);
      n++;
    end
    chk(n >= lo && n < lo + 12, 1'b1, "attach delay");
    @(negedge clk);
    chk(rep, 1'b1, "report");
    @(negedge clk);
    chk(rep, 1'b0, "report width");
  endtask : wait_up
  initial begin
    void'($urandom(74550));
    cyc(3);
    srst <= 0;
    wait_up(AC);
    $display("power-up done");
    cyc(1);
    rst_low <= 1;
    cyc(1 + $urandom % 2);
    rst_low <= 0;
    cyc(10);
    @(negedge clk);
    chk(hra, 1'b0, "glitch reset");
    chk(dp, 1'b1, "glitch dp");
    $display("glitch done");
    cyc(1);
    rst_low <= 1;
    cyc(10 + $urandom % 8);
    @(negedge clk);
    chk(hra, 1'b1, "hw reset");
    chk(dp, 1'b0, "dp in reset");
    cyc(1);
    rst_low <= 0;
    wait_up(AC);
    $display("reset pulse done");
    cyc(1);
    srst <= 1;
    rst_low <= 1;
    wake_req <= 1;
    cyc(3);
    srst <= 0;
    cyc(40);
    @(negedge clk);
    chk(dp, 1'b0, "held start-up");
    chk(wake_oe, 1'b1, "wake refused");
    cyc(1);
    rst_low <= 0;
    wake_req <= 0;
    wait_up(AC);
    $display("held reset done");
    cyc(1);
    wake_req <= 1;
    n = 0;
    while (wake_oe === 1'b1 && n < LC + 8) begin
      @(negedge clk);
      n++;
    end
    chk(n >= LC && n < LC + 5, 1'b1, "wake lead");
    chk(wake_in, 1'b0, "wake line");
    chk(wake_out, 1'b0, "wake data");
    cyc(1 + $urandom % 20);
    @(negedge clk);
    chk(wake_oe, 1'b0, "wake held");
    cyc(1);
    wake_req <= 0;
    cyc(3);
    @(negedge clk);
    chk(wake_oe, 1'b1, "wake release");
    $display("wake done");
    for (int i = 0; i < 8; i++) begin
      len = (i < 2) ? 3 + i : 1 + int'($urandom % 12);
      cyc(1);
      rst_low <= 1;
      cyc(len);
      rst_low <= 0;
      seen = 1'b0;
      repeat (8) begin
        @(negedge clk);
        seen = seen | hra;
      end
      chk(seen, exp_taken(len), "pulse taken");
      chk(dp, !exp_taken(len), "pulse dp");
      cyc(AC + 10);
      @(negedge clk);
      chk(dp, 1'b1, "pulse reboot");
    end
    $display("random pulses done");
    cyc(1);
    con <= 0;
    rst_low <= 1;
    cyc(30);
    @(negedge clk);
    chk(hra, 1'b0, "open pin");
    chk(dp, 1'b1, "open pin dp");
    $display("open pin done");
    print_verdict();
  end
endmodule : module_reset_wake_control_tb

// ==== dv/mrw_host.sv ====
`timescale 1ns/1ps
module mrw_host #(
  parameter int unsigned MAX_LOW = 50
) (
  // clock
  input wire logic clk,
  // bench requests
  input wire logic rst_low,
  input wire logic connected,
  // pins
  input wire logic wake_oe,
  input wire logic wake_out,
  output logic module_reset_in_n,
  output logic wake_in
);
  int unsigned low_cnt = 0;
  always_ff @(posedge clk) low_cnt <= rst_low ? low_cnt + 1 : 0;
  // low at most MAX_LOW cycles; an open pin floats high
  assign module_reset_in_n = !(connected && rst_low && low_cnt < MAX_LOW);
  // host pull-up on the wake line
  assign wake_in = wake_oe ? 1'b1 : wake_out;
endmodule : mrw_host

// ==== rtl/mrw_core.sv ====
`timescale 1ns/1ps
module mrw_core #(
  parameter longint unsigned ATTACH_CYC = mrw_pkg::ATTACH_DELAY_CYC,
  parameter longint unsigned LEAD_CYC = mrw_pkg::WAKE_LEAD_CYC
) (
  // clock and power-on reset
  input wire logic clk,
  input wire logic srst,
  // host reset pin
  input wire logic module_reset_in_n,
  input wire logic reset_pin_driven,
  // wake request from software, and wake line
  input wire logic wake_req,
  input wire logic wake_in,
  output logic wake_out,
  output logic wake_oe,
  // status
  output logic usb_dp_pullup,
  output logic startup_report,
  output logic hw_reset_active
);
  logic rst_s1_reg, rst_s1_next;
  logic rst_s2_reg, rst_s2_next;
  logic [2:0] flt_reg, flt_next;
  logic rst_low_reg, rst_low_next;
  logic [mrw_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic [mrw_pkg::CNT_W-1:0] wcnt_reg, wcnt_next;
  mrw_pkg::mrw_state_e st_reg, st_next;
  mrw_pkg::mrw_wake_e wk_reg, wk_next;
  logic dp_reg, dp_next;
  logic rep_reg, rep_next;
  logic woe_reg, woe_next;
  logic pin_level;

  // counter has covered its whole span
  function automatic logic span_done(logic [mrw_pkg::CNT_W-1:0] cnt, longint unsigned span);
    return cnt >= mrw_pkg::CNT_W'(span - 1);
  endfunction : span_done

  // unconnected pin reads high
  assign pin_level = reset_pin_driven ? module_reset_in_n : 1'b1;

  // reset input synchroniser and glitch filter
  always_comb begin
    rst_s1_next = pin_level;
    rst_s2_next = rst_s1_reg;
    flt_next = flt_reg;
    rst_low_next = rst_low_reg;
    if (rst_s2_reg) begin
      flt_next = 3'h0;
      rst_low_next = 1'b0;
    end else if (flt_reg != 3'(mrw_pkg::GLITCH_CYC - 1)) begin
      flt_next = flt_reg + 3'h1;
    end else begin
      rst_low_next = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= 1'b1;
      flt_reg <= 3'h0;
      rst_low_reg <= 1'b0;
    end else begin
      rst_s1_reg <= rst_s1_next;
      rst_s2_reg <= rst_s2_next;
      flt_reg <= flt_next;
      rst_low_reg <= rst_low_next;
    end
  end

  // start-up sequencer
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    dp_next = dp_reg;
    rep_next = 1'b0;
    if (rst_low_reg) begin
      st_next = mrw_pkg::ST_HOLD;
      cnt_next = '0;
      dp_next = 1'b0;
    end else begin
      case (st_reg)
        mrw_pkg::ST_POR: st_next = mrw_pkg::ST_BOOT;
        mrw_pkg::ST_HOLD: st_next = mrw_pkg::ST_BOOT;
        mrw_pkg::ST_BOOT: begin
          if (span_done(cnt_reg, ATTACH_CYC)) begin
            st_next = mrw_pkg::ST_REPORT;
            dp_next = 1'b1;
          end else begin
            cnt_next = cnt_reg + 1'b1;
          end
        end
        mrw_pkg::ST_REPORT: begin
          rep_next = 1'b1;
          st_next = mrw_pkg::ST_RUN;
        end
        mrw_pkg::ST_RUN: st_next = mrw_pkg::ST_RUN;
        default: st_next = mrw_pkg::ST_POR;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= mrw_pkg::ST_POR;
      cnt_reg <= '0;
      dp_reg <= 1'b0;
      rep_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      dp_reg <= dp_next;
      rep_reg <= rep_next;
    end
  end

  // wake sequencer
  always_comb begin
    wk_next = wk_reg;
    wcnt_next = wcnt_reg;
    woe_next = 1'b1;
    if (st_reg != mrw_pkg::ST_RUN) begin
      wk_next = mrw_pkg::WK_IDLE;
      wcnt_next = '0;
    end else begin
      case (wk_reg)
        mrw_pkg::WK_IDLE: begin
          wcnt_next = '0;
          if (wake_req) wk_next = mrw_pkg::WK_LEAD;
        end
        mrw_pkg::WK_LEAD: begin
          if (span_done(wcnt_reg, LEAD_CYC)) begin
            wk_next = mrw_pkg::WK_LOW;
            woe_next = 1'b0;
          end else begin
            wcnt_next = wcnt_reg + 1'b1;
          end
        end
        mrw_pkg::WK_LOW: begin
          woe_next = 1'b0;
          if (!wake_req) wk_next = mrw_pkg::WK_IDLE;
        end
        default: wk_next = mrw_pkg::WK_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wk_reg <= mrw_pkg::WK_IDLE;
      wcnt_reg <= '0;
      woe_reg <= 1'b1;
    end else begin
      wk_reg <= wk_next;
      wcnt_reg <= wcnt_next;
      woe_reg <= woe_next;
    end
  end

  assign wake_out = 1'b0;
  assign wake_oe = woe_reg;
  assign usb_dp_pullup = dp_reg;
  assign startup_report = rep_reg;
  assign hw_reset_active = rst_low_reg;

  a_glitch_ignored: assert property (@(posedge clk) disable iff (srst)
    $rose(rst_low_reg) |-> $past(!rst_s2_reg, 3))
    else $error("reset taken on a short glitch");
  a_dp_hold: assert property (@(posedge clk) disable iff (srst)
    rst_low_reg |=> !usb_dp_pullup)
    else $error("d+ raised while reset held");
  a_dp_after_boot: assert property (@(posedge clk) disable iff (srst)
    $rose(usb_dp_pullup) |-> $past(st_reg) == mrw_pkg::ST_BOOT)
    else $error("d+ raised outside boot");
  a_report_after_dp: assert property (@(posedge clk) disable iff (srst)
    $rose(usb_dp_pullup) |=> startup_report)
    else $error("no start-up report after attach");
  a_wake_never_high: assert property (@(posedge clk) disable iff (srst)
    !wake_oe |-> !wake_out && $past(st_reg) == mrw_pkg::ST_RUN)
    else $error("wake driven high or outside run");
  a_wake_lead_high: assert property (@(posedge clk) disable iff (srst)
    $fell(wake_oe) |-> $past(wk_reg) == mrw_pkg::WK_LEAD)
    else $error("wake pulled low without lead-in");
  a_reset_drops_dp: assert property (@(posedge clk) disable iff (srst)
    $rose(rst_low_reg) |=> !usb_dp_pullup && st_reg == mrw_pkg::ST_HOLD)
    else $error("reset did not restart start-up");
  a_unconnected_safe: assert property (@(posedge clk) disable iff (srst)
    !reset_pin_driven [*5] |-> !hw_reset_active)
    else $error("unconnected reset pin caused reset");
  a_report_single: assert property (@(posedge clk) disable iff (srst)
    startup_report |=> !startup_report)
    else $error("start-up report longer than one cycle");
  a_dp_full_count: assert property (@(posedge clk) disable iff (srst)
    $rose(usb_dp_pullup) |-> $past(cnt_reg) == mrw_pkg::CNT_W'(ATTACH_CYC - 1))
    else $error("d+ raised before attach delay elapsed");
  a_lead_full_count: assert property (@(posedge clk) disable iff (srst)
    $fell(wake_oe) |-> $past(wcnt_reg) == mrw_pkg::CNT_W'(LEAD_CYC - 1))
    else $error("wake lead-in cut short");
  a_hold_dp_low: assert property (@(posedge clk) disable iff (srst)
    st_reg == mrw_pkg::ST_HOLD |-> !usb_dp_pullup)
    else $error("d+ high while start-up held");
  a_hold_in_reset: assert property (@(posedge clk) disable iff (srst)
    hw_reset_active |=> st_reg == mrw_pkg::ST_HOLD)
    else $error("start-up ran during reset");
  a_reset_follows_pin: assert property (@(posedge clk) disable iff (srst)
    hw_reset_active |-> !$past(rst_s2_reg))
    else $error("reset held after pin went high");
  a_release_on_pin: assert property (@(posedge clk) disable iff (srst)
    $fell(hw_reset_active) |-> $past(rst_s2_reg))
    else $error("reset released while pin low");
endmodule : mrw_core

// ==== rtl/mrw_pkg.sv ====
package mrw_pkg;
  // clock
  localparam int unsigned CLK_HZ = 50_000_000;
  // power valid to attach, seconds
  localparam int unsigned ATTACH_DELAY_S = 14;
  localparam longint unsigned ATTACH_DELAY_CYC = longint'(ATTACH_DELAY_S) * CLK_HZ;
  // wake line high lead-in before pulling low, seconds
  localparam int unsigned WAKE_LEAD_S = 1;
  localparam longint unsigned WAKE_LEAD_CYC = longint'(WAKE_LEAD_S) * CLK_HZ;
  // reset input glitch filter length, cycles
  localparam int unsigned GLITCH_CYC = 4;
  // counter width
  localparam int unsigned CNT_W = 32;
  typedef enum {
    ST_POR,
    ST_HOLD,
    ST_BOOT,
    ST_REPORT,
    ST_RUN
  } mrw_state_e;
  typedef enum {
    WK_IDLE,
    WK_LEAD,
    WK_LOW
  } mrw_wake_e;
endpackage : mrw_pkg
